// ### rtl/cdm_top.sv
// two 14-bit counter/delay cells with clock select, chaining and edge modes
// assumes all oscillator and matrix inputs are synchronous to clock and
// that configuration inputs stay static while running
`timescale 1ns/1ps
`default_nettype none
`include "cdm_cfg.svh"

// rise and fall of a level sampled on clock; the previous sample follows
// the level through reset too, so a pin already high at release shows no
// false edge and a counter does not take a spurious first tick
module cdm_edge_sense #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  import cdm_pkg::*;

  logic [WIDTH-1:0] prev_reg;

  always_ff @(posedge clock) begin
    prev_reg <= level;
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule : cdm_edge_sense

// one counter/delay cell; HAS_WAKE adds the wake/sleep function of cell zero
module cdm_cell #(
  parameter int COUNT_WIDTH = `CDM_COUNT_WIDTH,
  parameter bit HAS_WAKE = 1'b0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] clock_sources,
  input wire logic cell_in,
  input wire logic wake_osc_down,
  input wire logic [COUNT_WIDTH-1:0] count_value,
  input wire logic [2:0] clock_select,
  input wire logic [1:0] edge_select,
  input wire logic [1:0] function_select,
  input wire logic wake_down_state,
  output logic cell_out,
  output logic terminal,
  output logic osc_request
);
  import cdm_pkg::*;

  logic [COUNT_WIDTH-1:0] count_reg;
  logic [COUNT_WIDTH-1:0] count_next;
  logic out_reg;
  logic out_next;
  logic term_reg;
  logic term_next;
  // level the output takes when a running delay expires
  logic target_reg;
  logic target_next;
  logic osc_reg;
  cdm_delay_state_type state_reg;
  cdm_delay_state_type state_next;

  // selected clock is sampled; a tick is its rising edge in this domain
  wire logic src_level = clock_sources[clock_select];
  logic tick;
  cdm_edge_sense #(.WIDTH(1)) src_sense (
    .clock(clock),
    .level(src_level),
    .rise(tick),
    .fall()
  );
  // the source runs freely, so a tick may land right after an input edge
  // and the first period comes out short

  logic in_rise;
  logic in_fall;
  cdm_edge_sense #(.WIDTH(1)) in_sense (
    .clock(clock),
    .level(cell_in),
    .rise(in_rise),
    .fall(in_fall)
  );
  wire logic in_change = in_rise | in_fall;

  wire logic sel_both = (edge_select == `CDM_EDGE_BOTH);
  wire logic sel_fall = (edge_select == `CDM_EDGE_FALL);
  wire logic sel_rise = (edge_select == `CDM_EDGE_RISE);
  wire logic sel_none = (edge_select == `CDM_EDGE_NONE);

  wire logic edge_hit = (sel_both & in_change) | (sel_fall & in_fall) |
                        (sel_rise & in_rise);

  // high-level reset holds the counter while the input is high
  wire logic count_clear = sel_none ? cell_in : edge_hit;

  wire logic is_delay = (function_select == `CDM_FUNC_DELAY);
  wire logic is_count = (function_select == `CDM_FUNC_COUNT);
  wire logic is_edge = (function_select == `CDM_FUNC_EDGE);
  // code 11 is wake/sleep only where the cell has it; elsewhere reserved
  wire logic is_wake = HAS_WAKE && (function_select == `CDM_FUNC_WAKE);

  wire logic count_zero = (count_reg == '0);
  // a zero count reloads or ends the delay instead of decrementing, so this never wraps
  wire logic [COUNT_WIDTH-1:0] count_dec = count_reg - COUNT_WIDTH'(1);

  always_comb begin
    count_next = count_reg;
    out_next = out_reg;
    term_next = 1'b0;
    target_next = target_reg;
    state_next = state_reg;
    if (is_delay) begin
      if (sel_none) begin
        out_next = cell_in;
        state_next = CDM_IDLE;
      end else if (edge_hit) begin
        // start a delay: count_value+1 ticks until the output moves
        // a new selected edge restarts a running delay with the new target
        count_next = count_value;
        target_next = cell_in;
        state_next = CDM_RUN;
      end else if (in_change) begin
        // an edge that is not delayed passes at once and cancels a delay
        out_next = cell_in;
        state_next = CDM_IDLE;
      end else begin
        // ticks on the edge that starts a delay are not counted, so each
        // delay counts from the next tick after the edge, which may come one cycle later
        case (state_reg)
          CDM_RUN: begin
            if (tick && count_zero) begin
              out_next = target_reg;
              state_next = CDM_IDLE;
            end else if (tick) begin
              count_next = count_dec;
            end
          end
          CDM_IDLE: begin
            // the output keeps its level until the next input edge
            state_next = CDM_IDLE;
          end
          default: begin
            // an illegal code falls back to idle rather than lock up
            state_next = CDM_IDLE;
          end
        endcase
      end
    end else if (is_count || is_wake) begin
      state_next = CDM_IDLE;
      if (is_wake && wake_osc_down) begin
        // powered down: the output parks at the configured level and the
        // count restarts from the top once the oscillator runs again
        out_next = wake_down_state;
        count_next = count_value;
      end else if (count_clear) begin
        // a reset condition beats a tick in the same cycle, so a reload is
        // never lost to a decrement
        count_next = count_value;
        out_next = 1'b0;
      end else if (tick) begin
        if (count_zero) begin
          // reload and keep counting: period is count_value+1
          count_next = count_value;
          term_next = 1'b1;
          out_next = 1'b1;
        end else begin
          count_next = count_dec;
          out_next = 1'b0;
        end
      end
    end else if (is_edge) begin
      // one-cycle pulse on each selected input edge
      // the pulse is one system cycle wide whatever clock is selected
      out_next = edge_hit;
      state_next = CDM_IDLE;
    end else begin
      // reserved function code: cell parks with its output low
      out_next = 1'b0;
      state_next = CDM_IDLE;
    end
  end

  // in counter mode with high-level reset the oscillator only needs to run
  // while the reset input is low, which saves its standby current
  wire logic osc_next = (is_count && sel_none) ? ~cell_in : 1'b1;

  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= COUNT_WIDTH'(`CDM_COUNT_RESET);
      out_reg <= 1'b0;
      term_reg <= 1'b0;
      target_reg <= 1'b0;
      osc_reg <= 1'b1;
      state_reg <= CDM_IDLE;
    end else begin
      count_reg <= count_next;
      out_reg <= out_next;
      term_reg <= term_next;
      target_reg <= target_next;
      osc_reg <= osc_next;
      state_reg <= state_next;
    end
  end

  assign cell_out = out_reg;
  assign terminal = term_reg;
  assign osc_request = osc_reg;

endmodule : cdm_cell

// cells zero and one of the ten; the 8-bit cells and the state-machine
// and ramp options of other cells are not part of this pair
module cdm_top (
  input wire logic clock,
  input wire logic reset,
  input wire logic rc_osc_clock,
  input wire logic rc_osc_div_four,
  input wire logic rc_osc_div_twentyfour,
  input wire logic rc_osc_div_sixtyfour,
  input wire logic low_freq_osc_clock,
  input wire logic ring_osc_clock,
  input wire logic cell_nine_terminal,
  input wire logic first_matrix_clock_line,
  input wire logic second_matrix_clock_line,
  input wire logic first_matrix_cell_in,
  input wire logic second_matrix_cell_in,
  input wire logic wake_osc_down,
  input wire cdm_pkg::cdm_cell_cfg_type cell_zero_cfg,
  input wire cdm_pkg::cdm_cell_cfg_type cell_one_cfg,
  output logic first_matrix_cell_out,
  output logic cell_zero_terminal,
  output logic cell_zero_osc_request,
  output logic second_matrix_cell_out,
  output logic cell_one_terminal,
  output logic cell_one_osc_request
);
  import cdm_pkg::*;

  // source vectors are indexed by the clock select code
  wire logic [7:0] zero_sources = {
    first_matrix_clock_line, ring_osc_clock, cell_nine_terminal,
    low_freq_osc_clock, rc_osc_div_sixtyfour, rc_osc_div_twentyfour,
    rc_osc_div_four, rc_osc_clock};

  wire logic [7:0] one_sources = {
    second_matrix_clock_line, ring_osc_clock, cell_zero_terminal,
    low_freq_osc_clock, rc_osc_div_sixtyfour, rc_osc_div_twentyfour,
    rc_osc_div_four, rc_osc_clock};

  // cell zero sits on the first matrix, cell one on the second
  cdm_cell #(.COUNT_WIDTH(`CDM_COUNT_WIDTH), .HAS_WAKE(1'b1)) cell_zero (
    .clock(clock),
    .reset(reset),
    .clock_sources(zero_sources),
    .cell_in(first_matrix_cell_in),
    .wake_osc_down(wake_osc_down),
    .count_value(cell_zero_cfg.count_value),
    .clock_select(cell_zero_cfg.clock_select),
    .edge_select(cell_zero_cfg.edge_select),
    .function_select(cell_zero_cfg.function_select),
    .wake_down_state(cell_zero_cfg.wake_down_state),
    .cell_out(first_matrix_cell_out),
    .terminal(cell_zero_terminal),
    .osc_request(cell_zero_osc_request)
  );

  // cell one has no wake/sleep function, so its power-down input is tied low
  cdm_cell #(.COUNT_WIDTH(`CDM_COUNT_WIDTH), .HAS_WAKE(1'b0)) cell_one (
    .clock(clock),
    .reset(reset),
    .clock_sources(one_sources),
    .cell_in(second_matrix_cell_in),
    .wake_osc_down(1'b0),
    .count_value(cell_one_cfg.count_value),
    .clock_select(cell_one_cfg.clock_select),
    .edge_select(cell_one_cfg.edge_select),
    .function_select(cell_one_cfg.function_select),
    .wake_down_state(cell_one_cfg.wake_down_state),
    .cell_out(second_matrix_cell_out),
    .terminal(cell_one_terminal),
    .osc_request(cell_one_osc_request)
  );

endmodule : cdm_top
`default_nettype wire

// ### rtl/cdm_cfg.svh
// constants for the counter/delay macrocell pair: field codes and widths
// assumes inclusion by bare name from the package and the top design file
`ifndef CDM_CFG_SVH
`define CDM_CFG_SVH

`define CDM_COUNT_WIDTH 14
`define CDM_COUNT_RESET 14'h0000

`define CDM_FUNC_DELAY 2'h0
`define CDM_FUNC_COUNT 2'h1
`define CDM_FUNC_EDGE 2'h2
`define CDM_FUNC_WAKE 2'h3

`define CDM_EDGE_BOTH 2'h0
`define CDM_EDGE_FALL 2'h1
`define CDM_EDGE_RISE 2'h2
`define CDM_EDGE_NONE 2'h3

`define CDM_CLK_RC 3'h0
`define CDM_CLK_DIV4 3'h1
`define CDM_CLK_DIV24 3'h2
`define CDM_CLK_DIV64 3'h3
`define CDM_CLK_LF 3'h4
`define CDM_CLK_CHAIN 3'h5
`define CDM_CLK_RING 3'h6
`define CDM_CLK_MATRIX 3'h7

`endif

// ### rtl/cdm_pkg.sv
// types shared by the counter/delay macrocell design
// assumes cdm_cfg.svh is on the include path
`include "cdm_cfg.svh"

package cdm_pkg;

  // static settings of one cell, held in one-time configuration memory
  typedef struct packed {
    logic [`CDM_COUNT_WIDTH-1:0] count_value;
    logic [2:0] clock_select;
    logic [1:0] edge_select;
    logic [1:0] function_select;
    logic wake_down_state;
  } cdm_cell_cfg_type;

  typedef enum logic [1:0] {
    CDM_IDLE = 2'b01,
    CDM_RUN = 2'b10
  } cdm_delay_state_type;

endpackage : cdm_pkg

// ### verification/cdm_src_model.sv
// free-running oscillator and matrix clock sources for the cell pair
// assumes the bench clock; sources are never reset, so their phase is arbitrary
`timescale 1ns/1ps
`default_nettype none
module cdm_src_model (
  input wire logic clock,
  output logic [7:0] src
);
  logic [9:0] cnt_reg = 10'h000;
  // source i has period 2^(i+2), so every tick has a low and a high cycle
  always_ff @(posedge clock) begin
    cnt_reg <= cnt_reg + 10'h001;
  end
  assign src = cnt_reg[8:1];
endmodule : cdm_src_model
`default_nettype wire

// ### verification/cdm_top_sva.sv
// checker for the counter/delay pair, bound to cdm_top
// assumes the configuration only changes while reset is high
`timescale 1ns/1ps
`default_nettype none
module cdm_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic first_matrix_cell_in,
  input wire logic second_matrix_cell_in,
  input wire logic wake_osc_down,
  input wire cdm_pkg::cdm_cell_cfg_type cell_zero_cfg,
  input wire cdm_pkg::cdm_cell_cfg_type cell_one_cfg,
  input wire logic first_matrix_cell_out,
  input wire logic cell_zero_terminal,
  input wire logic cell_zero_osc_request,
  input wire logic second_matrix_cell_out,
  input wire logic cell_one_terminal,
  input wire logic cell_one_osc_request
);
  import cdm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire logic [3:0] m0 = {cell_zero_cfg.function_select, cell_zero_cfg.edge_select};
  wire logic in0 = first_matrix_cell_in;
  wire logic [3:0] m1 = {cell_one_cfg.function_select, cell_one_cfg.edge_select};
  wire logic in1 = second_matrix_cell_in;
  chk_term_zero_pulse: assert property (cell_zero_terminal |=> !cell_zero_terminal)
    else $error("cell zero terminal wider than one cycle");
  chk_term_one_pulse: assert property (cell_one_terminal |=> !cell_one_terminal)
    else $error("cell one terminal wider than one cycle");
  chk_level_hold: assert property (m0 == 4'h7 && in0 |=>
    !cell_zero_terminal && !first_matrix_cell_out) else $error("counted during level reset");
  chk_osc_power: assert property (1'b1 |=>
    cell_zero_osc_request == !($past(m0) == 4'h7 && $past(in0)))
    else $error("oscillator request wrong");
  chk_none_pass: assert property (m0 == 4'h3 |=> first_matrix_cell_out == $past(in0))
    else $error("edge none output does not follow input");
  chk_wake_level: assert property (m0[3:2] == 2'h3 && wake_osc_down |=>
    first_matrix_cell_out == $past(cell_zero_cfg.wake_down_state))
    else $error("wake output not fixed while powered down");
  chk_edge_never: assert property (m0 == 4'hb |=> !first_matrix_cell_out)
    else $error("edge detect pulsed with no edge selected");
  chk_reserved_low: assert property (cell_one_cfg.function_select == 2'h3 |=>
    !second_matrix_cell_out) else $error("reserved function drives output");
  chk_osc_one_power: assert property (1'b1 |=>
    cell_one_osc_request == !($past(m1) == 4'h7 && $past(in1)))
    else $error("cell one oscillator request wrong");
  chk_edge_rise_pulse: assert property (m0 == 4'ha |=>
    first_matrix_cell_out == ($past(in0) && !$past(in0, 2)))
    else $error("edge detect pulse wrong for rising edge");
  chk_count_edge_reset: assert property (m0 == 4'h6 && $rose(in0) |=>
    !first_matrix_cell_out && !cell_zero_terminal)
    else $error("counter not cleared by rising reset edge");
endmodule : cdm_chk
bind cdm_top cdm_chk cdm_chk_i (.clock, .reset, .first_matrix_cell_in, .second_matrix_cell_in,
  .wake_osc_down, .cell_zero_cfg, .cell_one_cfg, .first_matrix_cell_out, .cell_zero_terminal,
  .cell_zero_osc_request, .second_matrix_cell_out, .cell_one_terminal, .cell_one_osc_request);
`default_nettype wire

// ### verification/test_counter_delay_macrocell.sv
// self-checking bench: clock codes, chaining, delay edges, random modes
// assumes cdm_src_model for sources and the bound checker for the mode rules
`timescale 1ns/1ps
`default_nettype none
module test_counter_delay_macrocell;
  import cdm_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic in0 = 1'b0;
  logic in1 = 1'b0;
  logic wdown = 1'b0;
  logic o0, t0, o1, t1;
  logic [7:0] src;
  cdm_cell_cfg_type c0 = '0;
  cdm_cell_cfg_type c1 = '0;
  logic [31:0] seed = 32'h0000d751;
  logic [31:0] got;
  logic [13:0] n, m;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 clock = ~clock;
  cdm_src_model cdm_src_model_i (.clock, .src);
  cdm_top cdm_top_i (.clock, .reset, .rc_osc_clock(src[0]), .rc_osc_div_four(src[1]),
    .rc_osc_div_twentyfour(src[2]), .rc_osc_div_sixtyfour(src[3]),
    .low_freq_osc_clock(src[4]), .cell_nine_terminal(src[5]), .ring_osc_clock(src[6]),
    .first_matrix_clock_line(src[7]), .second_matrix_clock_line(src[7]),
    .first_matrix_cell_in(in0), .second_matrix_cell_in(in1), .wake_osc_down(wdown),
    .cell_zero_cfg(c0), .cell_one_cfg(c1), .first_matrix_cell_out(o0),
    .cell_zero_terminal(t0), .cell_zero_osc_request(), .second_matrix_cell_out(o1),
    .cell_one_terminal(t1), .cell_one_osc_request());
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // a delayed edge lands on the (v+1)th rc tick; ticks are four cycles apart
  function automatic logic [31:0] dly_hi(input logic [13:0] v);
    return 32'(v) * 4 + 6;
  endfunction : dly_hi
  task automatic check(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      failures++;
      $display("ERROR t=%0t got=%h want=%h..%h", $time, g, lo, hi);
    end
  endtask : check
  task automatic setup(input cdm_cell_cfg_type a, input cdm_cell_cfg_type b);
    reset <= 1'b1;
    c0 <= a;
    c1 <= b;
    in0 <= 1'b0;
    in1 <= 1'b0;
    wdown <= 1'b0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
  endtask : setup
  // first two terminals only align the phase; the third gap is measured
  task automatic period(input logic one);
    for (int k = 0; k < 3; k++) begin
      got = 0;
      do begin
        @(posedge clock);
        got++;
      end while ((one ? t1 : t0) !== 1'b1);
    end
  endtask : period
  task automatic step(input logic lvl, input logic dly, input logic [13:0] v);
    got = 0;
    in0 <= lvl;
    do begin
      @(posedge clock);
      got++;
    end while (o0 !== lvl);
    if (dly) check(got, dly_hi(v) - 4, dly_hi(v));
    else check(got, 32'h2, 32'h2);
  endtask : step
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    for (int c = 0; c < 8; c++) begin
      setup('{14'h0000, 3'(c), 2'h2, 2'h1, 1'b0}, '{14'h0000, 3'(c), 2'h2, 2'h1, 1'b0});
      period(1'b0);
      check(got, 32'h4 << c, 32'h4 << c);
      period(1'b1);
      check(got, 32'h4 << c, 32'h4 << c);
    end
    $display("test clock_select done");
    for (int k = 0; k < 3; k++) begin
      n = 14'(rnd() % 8);
      m = 14'(rnd() % 4);
      setup('{n, 3'h0, 2'h2, 2'h1, 1'b0}, '{m, 3'h5, 2'h2, 2'h1, 1'b0});
      period(1'b0);
      check(got, 32'(n + 1) * 4, 32'(n + 1) * 4);
      period(1'b1);
      check(got, 32'(n + 1) * 32'(m + 1) * 4, 32'(n + 1) * 32'(m + 1) * 4);
    end
    $display("test chain done");
    for (int e = 0; e < 4; e++) begin
      n = 14'(rnd() % 4);
      setup('{n, 3'h0, 2'(e), 2'h0, 1'b0}, '0);
      repeat (3) @(posedge clock);
      step(1'b1, e == 0 || e == 2, n);
      step(1'b0, e < 2, n);
    end
    $display("test delay done");
    for (int k = 0; k < 16; k++) begin
      n = 14'(rnd() % 4);
      setup('{n, 3'h0, 2'(k), 2'(k >> 2), rnd() % 2 == 1}, '{n, 3'h0, 2'(k), 2'(k >> 2), 1'b0});
      repeat (150) begin
        @(posedge clock);
        got = rnd();
        in0 <= (got[2:0] == 3'h0) ? ~in0 : in0;
        in1 <= (got[5:3] == 3'h0) ? ~in1 : in1;
        wdown <= (got[8:6] == 3'h0) ? ~wdown : wdown;
      end
    end
    $display("test random_modes done");
    stop_test();
  end
endmodule : test_counter_delay_macrocell
`default_nettype wire
